// [common/cpl_pkg.sv]
package cpl_pkg;
    // avalon register word addresses (byte address = word index * 4)
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STAT = 4'h1;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h2;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
    // ctrl fields
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_AUTOSW_EN = 1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0003;
    // stat fields
    localparam int ST_LOAD = 0;
    localparam int ST_HILIM = 1;
    localparam int ST_DISCH = 2;
    localparam int ST_CC = 3;
    localparam int ST_THERM = 4;
    localparam int ST_SW_ON = 5;
    localparam int ST_MODE_LSB = 8;
    // irq fields
    localparam int IRQ_LOAD_SET = 0;
    localparam int IRQ_LOAD_CLR = 1;
    localparam int IRQ_AUTOSW = 2;
    localparam int IRQ_THERM = 3;
    localparam int IRQ_BITS = 4;
    // mode codes {pin_a,pin_b,pin_c,limit_select}
    localparam logic [3:0] MODE_SDP_ND = 4'he;
    localparam logic [3:0] MODE_CDP = 4'hf;
    localparam logic [3:0] MODE_SDP1_LO = 4'hc;
    localparam logic [3:0] MODE_SDP1_HI = 4'hd;
    // timing
    localparam longint CLK_HZ = 40000000;
    localparam longint TB_US = 1000;
    localparam longint TB_CYC = CLK_HZ * TB_US / 1000000;
    localparam longint ASSERT_MS = 200;
    localparam longint RELEASE_MS = 3000;
    localparam longint DISCH_MS = 100;
    localparam int ASSERT_TICKS = int'(ASSERT_MS * 1000 / TB_US);
    localparam int RELEASE_TICKS = int'(RELEASE_MS * 1000 / TB_US);
    localparam int DISCH_TICKS = int'(DISCH_MS * 1000 / TB_US);
    localparam int BELOW_MARGIN_MA = 10;
    typedef enum logic [2:0] {
        PS_OFF, PS_CDP, PS_DISCH, PS_SDP_AUTO, PS_SDP, PS_DCP, PS_THERM
    } cpl_port_e;
endpackage : cpl_pkg

// [core/cpl_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module cpl_sync #(
    parameter int W = 1
) (
    input wire logic i_clock, // clock
    input wire logic i_srst, // reset
    input wire logic [W-1:0] i_async, // pin level
    output logic [W-1:0] o_sync // synchronised level
);
    logic [W-1:0] meta_reg;
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            meta_reg <= '0;
            o_sync <= '0;
        end else begin
            meta_reg <= i_async;
            o_sync <= meta_reg;
        end
    end
endmodule : cpl_sync
`default_nettype wire

// [core/cpl_qual_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module cpl_qual_timer #(
    parameter int TICKS = 200
) (
    input wire logic i_clock, // clock
    input wire logic i_srst, // reset
    input wire logic i_ce, // clock enable
    input wire logic i_tick, // timebase tick
    input wire logic i_cond, // qualifying condition
    output logic o_done // condition held TICKS ticks
);
    logic [31:0] cnt_reg;
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            cnt_reg <= '0;
            o_done <= 1'b0;
        end else if (i_ce) begin
            if (!i_cond) begin
                cnt_reg <= '0;
                o_done <= 1'b0;
            end else if (i_tick && !o_done) begin
                if (cnt_reg == 32'(TICKS - 1)) o_done <= 1'b1;
                cnt_reg <= cnt_reg + 32'h1;
            end
        end
    end
endmodule : cpl_qual_timer
`default_nettype wire

// [core/cpl_load_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module cpl_load_ctrl
    import cpl_pkg::*;
#(
    parameter int ASSERT_T = cpl_pkg::ASSERT_TICKS,
    parameter int RELEASE_T = cpl_pkg::RELEASE_TICKS,
    parameter int DISCH_T = cpl_pkg::DISCH_TICKS,
    parameter int TB_DIV = int'(cpl_pkg::TB_CYC)
) (
    input wire logic i_clock, // 40 MHz clock
    input wire logic i_srst, // sync reset
    input wire logic i_ce, // clock enable
    input wire logic i_mode_control_pin_a, // control pin a
    input wire logic i_mode_control_pin_b, // control pin b
    input wire logic i_mode_control_pin_c, // control pin c
    input wire logic i_limit_select_input, // limit select pin
    input wire logic i_above_low, // comparator: load above low threshold
    input wire logic i_below_low_margin, // comparator: 10 mA below threshold
    input wire logic i_primary_det, // bc1.2 primary detection done
    input wire logic i_dcp_no_data, // phone took cdp as dcp, no data
    input wire logic i_sdp_connected, // phone connected as sdp
    input wire logic i_out_short, // output shorted
    input wire logic i_over_temp, // thermal shutdown sense
    input wire logic i_cooled, // cooled by hysteresis
    input wire logic [3:0] i_avm_address, // word address
    input wire logic i_avm_read, // read strobe
    input wire logic i_avm_write, // write strobe
    input wire logic [31:0] i_avm_writedata, // write data
    input wire logic [3:0] i_avm_byteenable, // byte enables
    output logic [31:0] o_avm_readdata, // read data
    output logic o_avm_waitrequest, // wait request
    output logic o_load_present_n, // load present, open drain low
    output logic o_load_present_oe, // drive enable of load present
    output logic o_use_high_limit, // select high current limit setting
    output logic o_switch_on, // power switch enable
    output logic o_const_current, // constant-current mode
    output logic o_discharge, // output discharge active
    output logic o_dp_dm_connect, // data lines connected
    output logic o_irq // interrupt level
);
    import cpl_pkg::*;

    ////////////////////////////////////////////////////////////////
    logic [3:0] pins_s;
    logic [6:0] ev_s;
    cpl_sync #(.W(4)) u_sync_pins (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_async({i_mode_control_pin_a, i_mode_control_pin_b,
                  i_mode_control_pin_c, i_limit_select_input}),
        .o_sync(pins_s)
    );
    cpl_sync #(.W(7)) u_sync_ev (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_async({i_above_low, i_below_low_margin, i_primary_det, i_dcp_no_data,
                  i_sdp_connected, i_out_short, i_over_temp}),
        .o_sync(ev_s)
    );
    logic above_s, below_s, prim_s, dcpnd_s, sdpc_s, short_s, hot_s;
    assign {above_s, below_s, prim_s, dcpnd_s, sdpc_s, short_s, hot_s} = ev_s;
    logic cooled_m_reg, cooled_s;
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            cooled_m_reg <= 1'b0;
            cooled_s <= 1'b0;
        end else begin
            cooled_m_reg <= i_cooled;
            cooled_s <= cooled_m_reg;
        end
    end

    ////////////////////////////////////////////////////////////////
    // timebase
    logic [31:0] tb_reg;
    logic tick;
    assign tick = (tb_reg == 32'(TB_DIV - 1));
    always_ff @(posedge i_clock) begin
        if (i_srst) tb_reg <= '0;
        else if (i_ce) tb_reg <= tick ? '0 : tb_reg + 32'h1;
    end

    ////////////////////////////////////////////////////////////////
    // registers
    logic [31:0] ctrl_reg;
    logic [IRQ_BITS-1:0] irq_stat_reg, irq_mask_reg, irq_ev;
    logic [31:0] stat_word;
    logic wr_ctrl, wr_istat, wr_imask;

    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        return r;
    endfunction : be_merge

    assign o_avm_waitrequest = 1'b0;
    assign wr_ctrl = i_avm_write && i_avm_address == ADDR_CTRL;
    assign wr_istat = i_avm_write && i_avm_address == ADDR_IRQ_STAT;
    assign wr_imask = i_avm_write && i_avm_address == ADDR_IRQ_MASK;

    always_ff @(posedge i_clock) begin
        if (i_srst) ctrl_reg <= CTRL_RESET;
        else if (i_ce && wr_ctrl) ctrl_reg <= be_merge(ctrl_reg, i_avm_writedata,
                                                        i_avm_byteenable);
    end
    always_ff @(posedge i_clock) begin
        if (i_srst) irq_mask_reg <= '0;
        else if (i_ce && wr_imask) irq_mask_reg <= be_merge(32'(irq_mask_reg),
                i_avm_writedata, i_avm_byteenable)[IRQ_BITS-1:0];
    end
    // set wins over write-one clear
    always_ff @(posedge i_clock) begin
        if (i_srst) irq_stat_reg <= '0;
        else if (i_ce) irq_stat_reg <= (irq_stat_reg & ~((wr_istat && i_avm_byteenable[0])
                ? i_avm_writedata[IRQ_BITS-1:0] : '0)) | irq_ev;
    end
    assign o_irq = |(irq_stat_reg & irq_mask_reg);

    always_ff @(posedge i_clock) begin
        if (i_srst) o_avm_readdata <= '0;
        else if (i_ce && i_avm_read) begin
            case (i_avm_address)
                ADDR_CTRL: o_avm_readdata <= ctrl_reg;
                ADDR_STAT: o_avm_readdata <= stat_word;
                ADDR_IRQ_STAT: o_avm_readdata <= 32'(irq_stat_reg);
                ADDR_IRQ_MASK: o_avm_readdata <= 32'(irq_mask_reg);
                default: o_avm_readdata <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // port mode machine
    cpl_port_e st_reg, st_next;
    logic [3:0] mode_prev_reg;
    logic [31:0] dcnt_reg;
    logic enable, mode_111;
    assign enable = ctrl_reg[CTRL_ENABLE];
    assign mode_111 = pins_s[3:1] == 3'b111;

    function automatic cpl_port_e mode_state(input logic [3:0] m);
        case (m)
            MODE_CDP: return PS_CDP;
            MODE_SDP_ND, MODE_SDP1_LO, MODE_SDP1_HI: return PS_SDP;
            default: return PS_DCP;
        endcase
    endfunction : mode_state

    always_comb begin
        st_next = st_reg;
        case (st_reg)
            PS_OFF: if (enable) st_next = mode_state(pins_s);
            PS_THERM: if (cooled_s && !hot_s) st_next = mode_state(pins_s);
            PS_DISCH: if (dcnt_reg == 32'(DISCH_T)) st_next = PS_SDP_AUTO;
            PS_SDP_AUTO: begin
                if (sdpc_s) st_next = PS_CDP;
                else if (pins_s != MODE_CDP) st_next = mode_state(pins_s);
            end
            PS_CDP: begin
                if (dcpnd_s && ctrl_reg[CTRL_AUTOSW_EN]) st_next = PS_DISCH;
                else if (pins_s != MODE_CDP) st_next = mode_state(pins_s);
            end
            PS_SDP, PS_DCP: st_next = mode_state(pins_s);
            default: st_next = PS_OFF;
        endcase
        if (!enable) st_next = PS_OFF;
        else if (hot_s) st_next = PS_THERM;
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) st_reg <= PS_OFF;
        else if (i_ce) st_reg <= st_next;
    end
    always_ff @(posedge i_clock) begin
        if (i_srst) mode_prev_reg <= '0;
        else if (i_ce) mode_prev_reg <= pins_s;
    end
    always_ff @(posedge i_clock) begin
        if (i_srst) dcnt_reg <= '0;
        else if (i_ce) begin
            if (st_reg != PS_DISCH) dcnt_reg <= '0;
            else if (tick) dcnt_reg <= dcnt_reg + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // load detection
    logic charging, as_done, rel_done, load_reg;
    assign charging = st_reg == PS_CDP || st_reg == PS_DCP;
    cpl_qual_timer #(.TICKS(ASSERT_T)) u_assert_t (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_ce(i_ce),
        .i_tick(tick),
        .i_cond(charging && above_s),
        .o_done(as_done)
    );
    cpl_qual_timer #(.TICKS(RELEASE_T)) u_release_t (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_ce(i_ce),
        .i_tick(tick),
        .i_cond(charging && below_s),
        .o_done(rel_done)
    );
    always_ff @(posedge i_clock) begin
        if (i_srst) load_reg <= 1'b0;
        else if (i_ce) begin
            if (!charging) load_reg <= 1'b0;
            else if (as_done || (st_reg == PS_CDP && prim_s)) load_reg <= 1'b1;
            else if (rel_done) load_reg <= 1'b0;
        end
    end
    // load indication is status only, never gates the limit
    assign o_load_present_n = 1'b0;
    assign o_load_present_oe = load_reg;

    ////////////////////////////////////////////////////////////////
    // power path
    logic sw_on;
    assign sw_on = st_reg != PS_OFF && st_reg != PS_THERM && st_reg != PS_DISCH;
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_switch_on <= 1'b0;
            o_const_current <= 1'b0;
            o_discharge <= 1'b0;
            o_use_high_limit <= 1'b1;
            o_dp_dm_connect <= 1'b0;
        end else if (i_ce) begin
            o_switch_on <= sw_on;
            o_const_current <= sw_on && short_s;
            o_discharge <= st_reg == PS_DISCH || st_reg == PS_OFF;
            o_use_high_limit <= (st_reg == PS_SDP) ? (pins_s == MODE_SDP1_HI) : 1'b1;
            o_dp_dm_connect <= st_reg == PS_CDP || st_reg == PS_SDP || st_reg == PS_SDP_AUTO;
        end
    end

    assign irq_ev = {st_reg != PS_THERM && st_next == PS_THERM,
                     st_reg == PS_CDP && st_next == PS_DISCH,
                     !charging && load_reg || charging && rel_done && load_reg && !as_done,
                     !load_reg && charging && (as_done || (st_reg == PS_CDP && prim_s))} & {4{i_ce}};

    assign stat_word = {16'h0, 4'h0, mode_prev_reg, 2'b00, o_switch_on,
                        st_reg == PS_THERM, o_const_current, o_discharge,
                        o_use_high_limit, load_reg} | (32'(mode_111) << 16);
endmodule : cpl_load_ctrl
`default_nettype wire

// [tb/cpl_load_ctrl_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module cpl_load_ctrl_chk #(
    parameter int ASSERT_T = 4,
    parameter int RELEASE_T = 6,
    parameter int TB_DIV = 4
) (
    input wire logic i_clock, // clock
    input wire logic i_srst, // reset
    input wire logic i_mode_control_pin_a, // pin a
    input wire logic i_mode_control_pin_b, // pin b
    input wire logic i_mode_control_pin_c, // pin c
    input wire logic i_limit_select_input, // limit select
    input wire logic i_above_low, // above low threshold
    input wire logic i_below_low_margin, // below threshold margin
    input wire logic i_primary_det, // primary detection
    input wire logic i_dcp_no_data, // phone took cdp as dcp
    input wire logic i_out_short, // output short
    input wire logic i_over_temp, // over temperature
    input wire logic o_load_present_oe, // load present drive
    input wire logic o_use_high_limit, // high limit select
    input wire logic o_switch_on, // switch on
    input wire logic o_const_current, // constant current
    input wire logic o_discharge, // discharge
    input wire logic o_dp_dm_connect // data lines
);
    logic [7:0] up_cnt;
    logic [7:0] dn_cnt;
    logic [7:0] prim_age;
    logic [3:0] mode;
    assign mode = {i_mode_control_pin_a, i_mode_control_pin_b, i_mode_control_pin_c,
                   i_limit_select_input};
    always_ff @(posedge i_clock) up_cnt <= !i_above_low ? 8'h0 : (&up_cnt ? up_cnt : up_cnt + 8'h1);
    always_ff @(posedge i_clock) dn_cnt <= !i_below_low_margin ? 8'h0 : (&dn_cnt ? dn_cnt : dn_cnt + 8'h1);
    always_ff @(posedge i_clock) prim_age <= (i_srst || i_primary_det) ? 8'h0 : (&prim_age ? prim_age : prim_age + 8'h1);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);
    chk_load_rise: assert property ($rose(o_load_present_oe) |->
        up_cnt >= 8'((ASSERT_T - 1) * TB_DIV) || prim_age < 8'h8) else $error("load present rose early");
    chk_load_fall: assert property ($fell(o_load_present_oe) && o_switch_on |->
        dn_cnt >= 8'((RELEASE_T - 1) * TB_DIV)) else $error("load present fell early");
    chk_limit_kept: assert property ($changed(o_load_present_oe) |-> $stable(o_use_high_limit))
        else $error("load indication moved the limit");
    chk_sdp_low: assert property ((mode == 4'he)[*6] ##0 o_switch_on |-> !o_use_high_limit)
        else $error("no-discharge sdp not at low limit");
    chk_cdp_high: assert property ((mode == 4'hf)[*6] ##0 o_switch_on |-> o_use_high_limit)
        else $error("cdp not at high limit");
    chk_no_disch: assert property ((($past(mode) == 4'he && mode == 4'hf) ||
        ($past(mode) == 4'hf && mode == 4'he)) && !o_discharge |-> !o_discharge[*6])
        else $error("discharge on sdp cdp change");
    chk_autosw_disch: assert property ($rose(i_dcp_no_data) && mode == 4'hf && o_switch_on &&
        o_dp_dm_connect |-> ##[1:8] o_discharge) else $error("auto switch gave no discharge");
    chk_short_cc: assert property (i_out_short[*5] ##0 o_switch_on |-> o_const_current)
        else $error("short without constant current");
    chk_therm_off: assert property (i_over_temp[*5] |-> !o_switch_on)
        else $error("switch on while over temperature");
endmodule : cpl_load_ctrl_chk
bind cpl_load_ctrl cpl_load_ctrl_chk #(.ASSERT_T(ASSERT_T), .RELEASE_T(RELEASE_T), .TB_DIV(TB_DIV)) u_chk (.*);
`default_nettype wire

// [tb/cpl_sys_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cpl_sys_model (
    input wire logic i_clock, // clock
    input wire logic i_srst, // reset
    input wire logic i_load_seen, // this port reports a load
    input wire logic i_other_load, // other port reports a load
    output logic o_limit_select // select to this port
);
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_limit_select <= 1'b1;
        end else begin
            // budget of one loaded port: park this one only while idle
            o_limit_select <= !(i_other_load && !i_load_seen);
        end
    end
endmodule : cpl_sys_model
`default_nettype wire

// [tb/charge_port_load_status_logic_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module charge_port_load_status_logic_bench;
    import cpl_pkg::*;
    logic i_clock = 1'b0;
    logic srst = 1'b1;
    logic above = 1'b0, below = 1'b0, prim = 1'b0, dcpnd = 1'b0, sdpc = 1'b0;
    logic shrt = 1'b0, otemp = 1'b0, cooled = 1'b0, other = 1'b0, rd = 1'b0, wr = 1'b0;
    logic ce = 1'b1, pin_a = 1'b1, pin_b = 1'b1, pin_c = 1'b1;
    logic [3:0] addr = 4'h0, be = 4'hf;
    logic [31:0] wdata = 32'h0, q, rdata;
    logic waitreq, load_n, load_oe, hi_lim, sw_on, cc, disch, dpdm, irq, sel, status_pin;
    int n_errors = 0, n_compared = 0, cyc = 0;
    always #12.5 i_clock = ~i_clock;
    assign status_pin = load_oe ? load_n : 1'b1;
    cpl_load_ctrl #(.ASSERT_T(4), .RELEASE_T(6), .DISCH_T(3), .TB_DIV(4)) uut (
        .i_clock(i_clock), .i_srst(srst), .i_ce(ce), .i_mode_control_pin_a(pin_a),
        .i_mode_control_pin_b(pin_b), .i_mode_control_pin_c(pin_c), .i_limit_select_input(sel),
        .i_above_low(above), .i_below_low_margin(below), .i_primary_det(prim),
        .i_dcp_no_data(dcpnd), .i_sdp_connected(sdpc), .i_out_short(shrt), .i_over_temp(otemp),
        .i_cooled(cooled), .i_avm_address(addr), .i_avm_read(rd), .i_avm_write(wr),
        .i_avm_writedata(wdata), .i_avm_byteenable(be), .o_avm_readdata(rdata),
        .o_avm_waitrequest(waitreq), .o_load_present_n(load_n), .o_load_present_oe(load_oe),
        .o_use_high_limit(hi_lim), .o_switch_on(sw_on), .o_const_current(cc),
        .o_discharge(disch), .o_dp_dm_connect(dpdm), .o_irq(irq));
    cpl_sys_model sys (.i_clock(i_clock), .i_srst(srst), .i_load_seen(!status_pin),
        .i_other_load(other), .o_limit_select(sel));
    task automatic test_done;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clock);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        do @(posedge i_clock); while (waitreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    // registered read data: the second read returns the first one's word
    task automatic rdchk(input string what, input logic [3:0] a, input logic [31:0] m,
                         input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        bus(1'b0, a, 32'h0);
        check(what, exp, q & m);
    endtask : rdchk
    task automatic waitc(input int n);
        repeat (n) @(posedge i_clock);
    endtask : waitc
    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 6000) begin
            n_errors++;
            test_done();
        end
    end
    initial begin
        waitc(4);
        srst <= 1'b0;
        waitc(8);
        check("use_high_limit", 1, hi_lim);
        check("switch_on", 1, sw_on);
        rdchk("ctrl", ADDR_CTRL, 32'hffffffff, CTRL_RESET);
        rdchk("unmapped", 4'h9, 32'hffffffff, 32'h0);
        above <= 1'b1;
        waitc(12);
        above <= 1'b0;
        waitc(1);
        above <= 1'b1;
        waitc(10);
        check("load early", 0, load_oe);
        waitc(20);
        check("load", 1, load_oe);
        check("limit kept", 1, hi_lim);
        rdchk("stat load", ADDR_STAT, 32'h1, 32'h1);
        bus(1'b1, ADDR_IRQ_MASK, 32'h1);
        waitc(1);
        check("irq", 1, irq);
        bus(1'b1, ADDR_IRQ_STAT, 32'h1);
        waitc(1);
        check("irq cleared", 0, irq);
        above <= 1'b0;
        below <= 1'b1;
        waitc(12);
        check("load held", 1, load_oe);
        waitc(30);
        check("load released", 0, load_oe);
        below <= 1'b0;
        other <= 1'b1;
        waitc(8);
        check("sdp limit", 0, hi_lim);
        check("sdp no discharge", 0, disch);
        other <= 1'b0;
        waitc(8);
        check("cdp limit", 1, hi_lim);
        check("cdp no discharge", 0, disch);
        prim <= 1'b1;
        waitc(6);
        check("primary load", 1, load_oe);
        prim <= 1'b0;
        below <= 1'b1;
        waitc(40);
        below <= 1'b0;
        dcpnd <= 1'b1;
        waitc(6);
        check("auto discharge", 1, disch);
        dcpnd <= 1'b0;
        rdchk("irq auto", ADDR_IRQ_STAT, 32'h4, 32'h4);
        waitc(20);
        check("discharge end", 0, disch);
        check("sdp data", 1, dpdm);
        sdpc <= 1'b1;
        waitc(8);
        sdpc <= 1'b0;
        check("back no discharge", 0, disch);
        bus(1'b1, ADDR_CTRL, 32'h0);
        shrt <= 1'b1;
        waitc(4);
        bus(1'b1, ADDR_CTRL, CTRL_RESET);
        waitc(4);
        check("short cc", 1, cc);
        otemp <= 1'b1;
        waitc(6);
        check("thermal off", 0, sw_on);
        otemp <= 1'b0;
        cooled <= 1'b1;
        waitc(6);
        check("restart", 1, sw_on);
        cooled <= 1'b0;
        otemp <= 1'b1;
        waitc(6);
        check("cycle off", 0, sw_on);
        test_done();
    end
endmodule : charge_port_load_status_logic_bench
`default_nettype wire
